// ### design/type_f_tx_edge_shaping_config.v
// Functional notes
// - codes 1..3 give one to three ramps.
// - codes 4..6 select table shaping modes.
// - upper nibble falling, lower nibble rising.
// - firmware codes: falling style is time constant.
// - table codes: falling style picks table.
// - firmware codes: rising style is time constant.
// - table codes: rising style picks table.
// - length bit seven doubles each state.
// - five-bit count of states, both edges.
// - residual amplitude scales carrier linearly.
// - separate sets for 212 and 424.
`timescale 1ns/1ps

module type_f_tx_edge_shaping_config (
  // AHB-Lite clock and reset.
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave port.
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Transmitter timing inputs, same clock domain.
  input  wire        carrier_tick,
  input  wire        fall_start,
  input  wire        rise_start,
  // Shaping controls to the driver.
  // All shaping controls come from flip-flops.
  output reg  [7:0]  residual_level,
  output reg  [1:0]  fall_ramps,
  output reg         fall_lut_en,
  output reg         fall_supply_adapt,
  output reg         fall_supply_corr,
  output reg  [2:0]  fall_time_const,
  output reg  [1:0]  fall_lut_sel,
  output reg  [1:0]  rise_ramps,
  output reg         rise_lut_en,
  output reg         rise_supply_adapt,
  output reg         rise_supply_corr,
  output reg  [2:0]  rise_time_const,
  output reg  [1:0]  rise_lut_sel,
  output wire [4:0]  edge_state_idx,
  output wire        edge_active
);

  `include "edge_shaping_defs.vh"

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  // Two complete parameter sets are kept so that software may prepare
  // the next rate while the current one is in use.
  // All settings reset to zero: the 212 kbit/s set, with no shaping.
  reg [7:0] resid_212_ff;          // Residual level, 212 kbit/s.
  reg [7:0] edge_type_212_ff;      // Edge kinds, 212 kbit/s.
  reg [7:0] edge_style_212_ff;     // Edge styles, 212 kbit/s.
  reg [7:0] edge_length_212_ff;    // Edge length, 212 kbit/s.
  reg [7:0] resid_424_ff;          // Residual level, 424 kbit/s.
  reg [7:0] edge_type_424_ff;      // Edge kinds, 424 kbit/s.
  reg [7:0] edge_style_424_ff;     // Edge styles, 424 kbit/s.
  reg [7:0] edge_length_424_ff;    // Edge length, 424 kbit/s.
  reg       rate_424_ff;           // High when the 424 set is used.

  // ****************************************************************
  // AHB-Lite address phase capture.
  // ****************************************************************
  // The slave never stalls: reads are answered from flip-flops loaded in
  // the address phase, and writes land at the end of the data phase,
  // when hwdata stands. Only a whole-word transfer is expected; a
  // narrower one still writes the low byte.
  reg       wr_pend_ff;            // Write data phase pending.
  reg [7:0] wr_addr_ff;            // Captured write address.
  wire      take;                  // Valid transfer accepted.

  // A transfer is taken only when the bus is ready and the master
  // marks it as non-sequential or sequential.
  assign take      = hsel && hready && htrans[1];
  // Every access completes at once with an okay response.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Word index of a byte address; the low two bits are the byte lane.
  // Address bits above the index are not decoded, so the bank repeats
  // through the address space.
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // Latches write address; zero wait states.
  // Only the data phase of a write is remembered; a read needs no
  // state because its data is loaded in the address phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take && hwrite;
      if (take) begin
        wr_addr_ff <= reg_index(haddr);
      end
    end
  end

  // Returns a byte with reserved bits forced to zero.
  // Used on every write but the rate control so that reserved bits are always stored as
  // zero and are ignored by the decoders.
  function [7:0] keep;
    input [7:0] val;
    input [7:0] mask;
    begin
      keep = val & mask;
    end
  endfunction

  // Writes registers in the data phase.
  // Settings change only here, so the residual level and decoded edge outputs
  // move just after a write and never on their own; the timer outputs follow starts and ticks.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resid_212_ff       <= `RST_BYTE;
      edge_type_212_ff   <= `RST_BYTE;
      edge_style_212_ff  <= `RST_BYTE;
      edge_length_212_ff <= `RST_BYTE;
      resid_424_ff       <= `RST_BYTE;
      edge_type_424_ff   <= `RST_BYTE;
      edge_style_424_ff  <= `RST_BYTE;
      edge_length_424_ff <= `RST_BYTE;
      rate_424_ff        <= 1'b0;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        `ADDR_RESID_212: begin
          resid_212_ff <= keep(hwdata[7:0], `MASK_RESID);
        end
        `ADDR_TYPE_212: begin
          edge_type_212_ff <= keep(hwdata[7:0], `MASK_TYPE);
        end
        `ADDR_STYLE_212: begin
          edge_style_212_ff <= keep(hwdata[7:0], `MASK_STYLE);
        end
        `ADDR_LENGTH_212: begin
          edge_length_212_ff <= keep(hwdata[7:0], `MASK_LENGTH);
        end
        `ADDR_RESID_424: begin
          resid_424_ff <= keep(hwdata[7:0], `MASK_RESID);
        end
        `ADDR_TYPE_424: begin
          edge_type_424_ff <= keep(hwdata[7:0], `MASK_TYPE);
        end
        `ADDR_STYLE_424: begin
          edge_style_424_ff <= keep(hwdata[7:0], `MASK_STYLE);
        end
        `ADDR_LENGTH_424: begin
          edge_length_424_ff <= keep(hwdata[7:0], `MASK_LENGTH);
        end
        // Bit zero selects the 424 kbit/s set; the other bits are unused.
        `ADDR_RATE_CTRL: begin
          rate_424_ff <= hwdata[0];
        end
        // Unmapped writes are dropped.
        // Reads of those indices return zero, except the active status index.
        default: begin
          rate_424_ff <= rate_424_ff;
        end
      endcase
    end
  end

  // ****************************************************************
  // Active set selection.
  // ****************************************************************
  // The rate bit switches every setting at once, so the driver never
  // sees a mix of the two sets.
  wire [7:0] act_type;             // Edge kinds in use.
  wire [7:0] act_style;            // Edge styles in use.
  wire [7:0] act_length;           // Edge length in use.

  assign act_type   = rate_424_ff ? edge_type_424_ff   : edge_type_212_ff;
  assign act_style  = rate_424_ff ? edge_style_424_ff  : edge_style_212_ff;
  assign act_length = rate_424_ff ? edge_length_424_ff : edge_length_212_ff;

  // The level is linear in carrier amplitude: zero holds no carrier and
  // all ones holds the full carrier during modulation.
  // The level follows the rate bit one cycle after a write.
  // residual level registered out.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      residual_level <= 8'h00;
    end else begin
      residual_level <= rate_424_ff ? resid_424_ff : resid_212_ff;
    end
  end

  // ****************************************************************
  // Edge decoders.
  // ****************************************************************
  // Each nibble of the active kind byte is decoded on its own, with its
  // style field; reserved codes decode to all zeros, leaving no shaping.
  wire [1:0] nxt_fall_ramps;       // Decoded falling ramp count.
  wire       nxt_fall_lut_en;      // Decoded falling table enable.
  wire       nxt_fall_adapt;       // Decoded falling supply adaptation.
  wire       nxt_fall_corr;        // Decoded falling supply correction.
  wire [2:0] nxt_fall_tc;          // Decoded falling time constant.
  wire [1:0] nxt_fall_sel;         // Decoded falling table number.
  wire [1:0] nxt_rise_ramps;       // Decoded rising ramp count.
  wire       nxt_rise_lut_en;      // Decoded rising table enable.
  wire       nxt_rise_adapt;       // Decoded rising supply adaptation.
  wire       nxt_rise_corr;        // Decoded rising supply correction.
  wire [2:0] nxt_rise_tc;          // Decoded rising time constant.
  wire [1:0] nxt_rise_sel;         // Decoded rising table number.

  // Falling edge uses the upper nibble and the upper style field.
  // falling nibble decode.
  edge_kind_decode u_fall (
    .kind           (act_type[`FALL_NIB_HI:`FALL_NIB_LO]),
    .style          (act_style[`FALL_STY_HI:`FALL_STY_LO]),
    .ramp_count     (nxt_fall_ramps),
    .lut_enable     (nxt_fall_lut_en),
    .supply_adapt   (nxt_fall_adapt),
    .supply_correct (nxt_fall_corr),
    .time_const     (nxt_fall_tc),
    .lut_index      (nxt_fall_sel)
  );

  // Rising edge uses the lower nibble and the lower style field.
  // rising nibble decode.
  edge_kind_decode u_rise (
    .kind           (act_type[`RISE_NIB_HI:`RISE_NIB_LO]),
    .style          (act_style[`RISE_STY_HI:`RISE_STY_LO]),
    .ramp_count     (nxt_rise_ramps),
    .lut_enable     (nxt_rise_lut_en),
    .supply_adapt   (nxt_rise_adapt),
    .supply_correct (nxt_rise_corr),
    .time_const     (nxt_rise_tc),
    .lut_index      (nxt_rise_sel)
  );

  // ****************************************************************
  // Registered shaping controls.
  // ****************************************************************
  // Registering the decode keeps glitches of the set mux away from the
  // analog driver; the cost is one cycle of latency after a write or a
  // change of rate.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_ramps        <= 2'd0;
      fall_lut_en       <= 1'b0;
      fall_supply_adapt <= 1'b0;
      fall_supply_corr  <= 1'b0;
      fall_time_const   <= 3'd0;
      fall_lut_sel      <= 2'd0;
      rise_ramps        <= 2'd0;
      rise_lut_en       <= 1'b0;
      rise_supply_adapt <= 1'b0;
      rise_supply_corr  <= 1'b0;
      rise_time_const   <= 3'd0;
      rise_lut_sel      <= 2'd0;
    end else begin
      fall_ramps        <= nxt_fall_ramps;
      fall_lut_en       <= nxt_fall_lut_en;
      fall_supply_adapt <= nxt_fall_adapt;
      fall_supply_corr  <= nxt_fall_corr;
      fall_time_const   <= nxt_fall_tc;
      fall_lut_sel      <= nxt_fall_sel;
      rise_ramps        <= nxt_rise_ramps;
      rise_lut_en       <= nxt_rise_lut_en;
      rise_supply_adapt <= nxt_rise_adapt;
      rise_supply_corr  <= nxt_rise_corr;
      rise_time_const   <= nxt_rise_tc;
      rise_lut_sel      <= nxt_rise_sel;
    end
  end

  // Either start pulse restarts the shared timer when the state count is not zero; a start during a
  // running edge begins the pattern again from its first state.
  // The timer counts carrier cycles, not bus clocks; carrier_tick must
  // be a one-cycle pulse per carrier cycle.
  // shared doubling and count.
  edge_len_timer u_timer (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .carrier_tick (carrier_tick),
    .edge_start   (fall_start | rise_start),
    .double_len   (act_length[`LEN_DOUBLE_BIT]),
    .state_count  (act_length[`LEN_COUNT_HI:`LEN_COUNT_LO]),
    .state_idx_ff (edge_state_idx),
    .edge_busy_ff (edge_active)
  );

  // ****************************************************************
  // Read data.
  // ****************************************************************
  // Reserved bits were cleared on the way in, so each register reads
  // back exactly what the shaping logic uses.
  reg [7:0] rd_byte;               // Selected read byte.

  // Picks the addressed register.
  // The mux reads the address phase directly, since hrdata is loaded
  // on the same edge that takes the read.
  always @* begin
    case (reg_index(haddr))
      `ADDR_RESID_212:   rd_byte = resid_212_ff;
      `ADDR_TYPE_212:    rd_byte = edge_type_212_ff;
      `ADDR_STYLE_212:   rd_byte = edge_style_212_ff;
      `ADDR_LENGTH_212:  rd_byte = edge_length_212_ff;
      `ADDR_RESID_424:   rd_byte = resid_424_ff;
      `ADDR_TYPE_424:    rd_byte = edge_type_424_ff;
      `ADDR_STYLE_424:   rd_byte = edge_style_424_ff;
      `ADDR_LENGTH_424:  rd_byte = edge_length_424_ff;
      `ADDR_RATE_CTRL:   rd_byte = {7'd0, rate_424_ff};
      `ADDR_ACTIVE_STAT: rd_byte = {2'd0, edge_active, edge_state_idx};
      default:           rd_byte = 8'h00;
    endcase
  end

  // Registers read data for the data phase.
  // The read word holds its value until the next read; upper bytes
  // are always zero.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule // type_f_tx_edge_shaping_config

// ### design/edge_shaping_defs.vh
`ifndef EDGE_SHAPING_DEFS_VH
`define EDGE_SHAPING_DEFS_VH

// Register word indices of the Type F shaping parameter bank; the byte
// address on the bus is four times the index.
`define ADDR_RESID_212     8'h34
`define ADDR_TYPE_212      8'h35
`define ADDR_STYLE_212     8'h36
`define ADDR_LENGTH_212    8'h37
`define ADDR_RESID_424     8'h38
`define ADDR_TYPE_424      8'h39
`define ADDR_STYLE_424     8'h3A
`define ADDR_LENGTH_424    8'h3B
// Selects the 424 kbit/s set; this is the rate control register.
`define ADDR_RATE_CTRL     8'h40
// Read-only view of the edge timer: busy flag and state index.
`define ADDR_ACTIVE_STAT   8'h44

// Writable bit masks; reserved bits read back as zero.
`define MASK_TYPE          8'hFF
`define MASK_STYLE         8'h77
`define MASK_LENGTH        8'h9F
`define MASK_RESID         8'hFF

// Reset values.
`define RST_BYTE           8'h00

// Field positions.
`define FALL_NIB_HI        7
`define FALL_NIB_LO        4
`define RISE_NIB_HI        3
`define RISE_NIB_LO        0
`define FALL_STY_HI        6
`define FALL_STY_LO        4
`define RISE_STY_HI        2
`define RISE_STY_LO        0
`define LEN_DOUBLE_BIT     7
`define LEN_COUNT_HI       4
`define LEN_COUNT_LO       0

// Edge kind codes.
`define KIND_RAMP1         4'h1
`define KIND_RAMP2         4'h2
`define KIND_RAMP3         4'h3
`define KIND_LUT_PLAIN     4'h4
`define KIND_LUT_CORR      4'h5
`define KIND_LUT_NOCORR    4'h6

`endif

// ### design/edge_kind_decode.v
`timescale 1ns/1ps

// ****************************************************************
// Decodes one edge kind nibble and its style field.
// ****************************************************************
module edge_kind_decode (
  // Selector inputs.
  input  wire [3:0] kind,
  input  wire [2:0] style,
  // Decoded controls.
  output reg  [1:0] ramp_count,
  output reg        lut_enable,
  output reg        supply_adapt,
  output reg        supply_correct,
  output reg  [2:0] time_const,
  output reg  [1:0] lut_index
);

  `include "edge_shaping_defs.vh"

  // Maps a code to its ramp count, table and supply options.
  always @* begin
    ramp_count     = 2'd0;
    lut_enable     = 1'b0;
    supply_adapt   = 1'b0;
    supply_correct = 1'b0;
    time_const     = 3'd0;
    lut_index      = 2'd0;
    case (kind)
      `KIND_RAMP1, `KIND_RAMP2, `KIND_RAMP3: begin
        ramp_count = kind[1:0];
        time_const = style;
      end
      `KIND_LUT_PLAIN: begin
        lut_enable = 1'b1;
        lut_index  = style[1:0];
      end
      `KIND_LUT_CORR: begin
        lut_enable     = 1'b1;
        supply_adapt   = 1'b1;
        supply_correct = 1'b1;
        lut_index      = style[1:0];
      end
      `KIND_LUT_NOCORR: begin
        lut_enable   = 1'b1;
        supply_adapt = 1'b1;
        lut_index    = style[1:0];
      end
      default: begin
        ramp_count = 2'd0;
      end
    endcase
  end

endmodule // edge_kind_decode

// ### design/edge_len_timer.v
`timescale 1ns/1ps

// ****************************************************************
// Counts carrier cycles per transition state.
// ****************************************************************
module edge_len_timer (
  // Clock and reset.
  input  wire       hclk,
  input  wire       hresetn,
  // Carrier cycle strobe and edge request.
  input  wire       carrier_tick,
  input  wire       edge_start,
  input  wire       double_len,
  input  wire [4:0] state_count,
  // Progress.
  output reg  [4:0] state_idx_ff,
  output reg        edge_busy_ff
);

  reg       half_ff;     // Second carrier cycle of a doubled state.
  reg [4:0] nxt_idx;     // Next state index.
  reg       nxt_busy;    // Next busy flag.
  reg       nxt_half;    // Next half flag.

  // Steps through the active states of one edge.
  always @* begin
    nxt_idx  = state_idx_ff;
    nxt_busy = edge_busy_ff;
    nxt_half = half_ff;
    if (edge_start && state_count != 5'd0) begin
      nxt_idx  = 5'd0;
      nxt_busy = 1'b1;
      nxt_half = 1'b0;
    end else if (edge_busy_ff && carrier_tick) begin
      if (double_len && !half_ff) begin
        nxt_half = 1'b1;
      end else begin
        nxt_half = 1'b0;
        if (state_idx_ff == state_count - 5'd1) begin
          nxt_busy = 1'b0;
        end else begin
          nxt_idx = state_idx_ff + 5'd1;
        end
      end
    end
  end

  // State registers.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_idx_ff <= 5'd0;
      edge_busy_ff <= 1'b0;
      half_ff      <= 1'b0;
    end else begin
      state_idx_ff <= nxt_idx;
      edge_busy_ff <= nxt_busy;
      half_ff      <= nxt_half;
    end
  end

endmodule // edge_len_timer

// ### verif/edge_shaping_asserts.sv
`timescale 1ns/1ps

// ****************************************************************
// Bus and decode checks on the shaping block's ports.
// ****************************************************************
module edge_shaping_asserts (
  // Clock, reset and bus.
  input wire       hclk,
  input wire       hresetn,
  input wire       hsel,
  input wire       hready,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       hreadyout,
  input wire       hresp,
  // Shaping outputs and timing inputs.
  input wire [7:0] residual_level,
  input wire [1:0] fall_ramps,
  input wire       fall_lut_en,
  input wire       fall_supply_adapt,
  input wire       fall_supply_corr,
  input wire [1:0] rise_ramps,
  input wire       rise_lut_en,
  input wire       carrier_tick,
  input wire       fall_start,
  input wire       rise_start,
  input wire [4:0] edge_state_idx,
  input wire       edge_active
);
  reg  wr_dph_ff;  // High during the data phase of a taken write.
  reg  wr_dph_d_ff; // High the cycle after, while outputs re-register.
  wire no_start;   // Neither edge is being requested.

  assign no_start = !fall_start && !rise_start;

  // Tracks write data phases, the only time settings may change.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dph_ff   <= 1'b0;
      wr_dph_d_ff <= 1'b0;
    end else begin
      wr_dph_d_ff <= wr_dph_ff;
      if (hready)
        wr_dph_ff <= hsel & htrans[1] & hwrite;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ready_high: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_fall_lut_ramp: assert property (fall_lut_en |-> fall_ramps == 2'd0)
    else $error("falling table mode also shows ramps");
  a_rise_lut_ramp: assert property (rise_lut_en |-> rise_ramps == 2'd0)
    else $error("rising table mode also shows ramps");
  a_corr_needs_adapt: assert property (fall_supply_corr |->
    fall_supply_adapt && fall_lut_en) else $error("correction without table");
  a_set_stable: assert property (!wr_dph_ff && !wr_dph_d_ff |=>
    $stable({residual_level, fall_ramps, rise_ramps, fall_lut_en,
    rise_lut_en}))
    else $error("settings changed without a write");
  a_no_self_start: assert property (!edge_active && no_start |=>
    !edge_active) else $error("edge began without a request");
  a_idx_hold: assert property (edge_active && !carrier_tick && no_start
    |=> $stable(edge_state_idx)) else $error("state moved without a tick");
  a_idx_step: assert property (edge_active && carrier_tick && no_start
    |=> !edge_active || $stable(edge_state_idx) ||
    edge_state_idx == $past(edge_state_idx) + 5'd1)
    else $error("state index skipped");
endmodule // edge_shaping_asserts

// ### verif/type_f_tx_edge_shaping_config_tb_top.sv
`timescale 1ns/1ps
`include "edge_shaping_defs.vh"

// ****************************************************************
// Self-checking bench for the Type F shaping settings.
// ****************************************************************
module type_f_tx_edge_shaping_config_tb_top;
  reg         hclk, hresetn, hsel, hwrite, carrier_tick;
  reg         fall_start, rise_start;
  reg  [31:0] haddr, hwdata, rd;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [7:0]  st;
  reg  [4:0]  df, dr;                 // Expected fall and rise decode.
  reg  [31:0] seed = 32'h0000_db23;   // Fixed seed for repeatable runs.
  wire        hready, hreadyout, hresp, edge_active;
  wire        fall_lut_en, fall_supply_adapt, fall_supply_corr;
  wire        rise_lut_en, rise_supply_adapt, rise_supply_corr;
  wire [31:0] hrdata;
  wire [7:0]  residual_level;
  wire [1:0]  fall_ramps, fall_lut_sel, rise_ramps, rise_lut_sel;
  wire [2:0]  fall_time_const, rise_time_const;
  wire [4:0]  edge_state_idx;
  integer     error_cnt = 0;
  integer     total_checks = 0;
  integer     i;

  // The one slave's ready is the bus ready.
  assign hready = hreadyout;

  // Free running 100 MHz clock.
  always #5 hclk = ~hclk;

  type_f_tx_edge_shaping_config dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .carrier_tick, .fall_start, .rise_start, .residual_level,
    .fall_ramps, .fall_lut_en, .fall_supply_adapt, .fall_supply_corr,
    .fall_time_const, .fall_lut_sel, .rise_ramps, .rise_lut_en,
    .rise_supply_adapt, .rise_supply_corr, .rise_time_const,
    .rise_lut_sel, .edge_state_idx, .edge_active);

  // Xorshift step for random stimulus.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected {ramps, table, adapt, correct} for one edge kind code.
  function automatic logic [4:0] dec(input logic [3:0] k);
    return {(k >= 1 && k <= 3) ? k[1:0] : 2'd0, k >= 4 && k <= 6,
      k == 5 || k == 6, k == 5};
  endfunction

  // Writable bits of a bank byte; reserved bits read as zero.
  function automatic logic [7:0] rmask(input logic [7:0] a);
    return a[1:0] == 2'd2 ? 8'h77 : a[1:0] == 2'd3 ? 8'h9F : 8'hFF;
  endfunction

  // Compares one value and counts the result.
  task automatic check(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single word transfer; read data lands in rd.
  task automatic ahb(input logic [7:0] a, input logic wr,
    input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, a, 2'b00};  // Byte address is four times index.
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // Runs one edge with ticks every cycle and counts ticks used.
  task automatic run_edge(input logic [7:0] len, input logic rise);
    integer n;
    n = 0;
    ahb(`ADDR_LENGTH_212, 1'b1, {24'h0000_00, len});
    @(posedge hclk);
    fall_start <= ~rise;
    rise_start <= rise;
    @(posedge hclk);
    fall_start <= 1'b0;
    rise_start <= 1'b0;
    carrier_tick <= 1'b1;
    @(negedge hclk);
    while (edge_active === 1'b1 && n < 80) begin
      n++;
      @(negedge hclk);
    end
    @(posedge hclk);
    carrier_tick <= 1'b0;
    check("ticks", n, len[4:0] * (len[7] ? 2 : 1));
    if (len[4:0] != 5'd0) begin
      check("idx", edge_state_idx, len[4:0] - 5'd1);
      ahb(`ADDR_ACTIVE_STAT, 1'b0, 32'h0);
      check("status", rd, len[4:0] - 5'd1);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence.
  initial begin
    {hclk, hresetn, hsel, hwrite, carrier_tick} = 5'b0;
    {fall_start, rise_start, haddr, hwdata, htrans} = 'b0;
    hsize = 3'b010;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 8'h34; i <= 8'h3C; i++) begin
      ahb(i[7:0], 1'b0, 32'h0);
      check("reset", rd, 32'h0);
    end
    for (i = 8'h34; i <= 8'h3C; i++) begin
      st = rnd();
      ahb(i[7:0], 1'b1, {24'hffff_ff, st});
      ahb(i[7:0], 1'b0, 32'h0);
      check("readback", rd, i == 8'h3C ? 0 : st & rmask(i));
    end
    $display("test registers done");
    for (i = 0; i < 16; i++) begin
      df = dec(i[3:0]);
      dr = dec(~i[3:0]);
      st = rnd() & {1'b0, ~df[2], 3'b110, ~dr[2], 2'b11};
      ahb(`ADDR_TYPE_212, 1'b1, {24'h0, i[3:0], ~i[3:0]});
      ahb(`ADDR_STYLE_212, 1'b1, {24'h0, st});
      repeat (2) @(negedge hclk);
      check("fall", {fall_ramps, fall_lut_en, fall_supply_adapt,
        fall_supply_corr}, df);
      check("rise", {rise_ramps, rise_lut_en, rise_supply_adapt,
        rise_supply_corr}, dr);
      if (df[4:3] != 0)
        check("ftc", fall_time_const, st[6:4]);
      if (df[2])
        check("fsel", fall_lut_sel, st[5:4]);
      if (dr[4:3] != 0)
        check("rtc", rise_time_const, st[2:0]);
      if (dr[2])
        check("rsel", rise_lut_sel, st[1:0]);
    end
    $display("test decode done");
    ahb(`ADDR_RESID_212, 1'b1, 32'h0);
    ahb(`ADDR_RESID_424, 1'b1, 32'hff);
    ahb(`ADDR_TYPE_424, 1'b1, 32'h51);
    ahb(`ADDR_RATE_CTRL, 1'b1, 32'h1);
    ahb(`ADDR_RATE_CTRL, 1'b0, 32'h0);
    check("rate", rd, 32'h1);
    @(negedge hclk);
    df = dec(4'h5);
    dr = dec(4'h1);
    check("lvl424", residual_level, 8'hFF);
    check("f424", {fall_ramps, fall_lut_en}, {df[4:3], df[2]});
    check("r424", rise_ramps, dr[4:3]);
    ahb(`ADDR_RATE_CTRL, 1'b1, 32'h0);
    repeat (2) @(negedge hclk);
    check("lvl212", residual_level, 8'h00);
    $display("test rate sets done");
    run_edge(8'h03, 1'b0);
    run_edge(8'h83, 1'b1);
    run_edge(8'hFF, 1'b0);
    run_edge(8'h01, 1'b1);
    run_edge(8'h00, 1'b0);
    $display("test edge timing done");
    summarize();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #200000;
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    summarize();
  end
endmodule // type_f_tx_edge_shaping_config_tb_top

bind type_f_tx_edge_shaping_config edge_shaping_asserts u_chk (.hclk,
  .hresetn, .hsel, .hready, .htrans, .hwrite, .hreadyout, .hresp,
  .residual_level, .fall_ramps, .fall_lut_en, .fall_supply_adapt,
  .fall_supply_corr, .rise_ramps, .rise_lut_en, .carrier_tick,
  .fall_start, .rise_start, .edge_state_idx, .edge_active);
